// ===== core/usb_audio_fn.sv
// usb audio function control: descriptors, requests, volume/mute, keys, suspend
`timescale 1ns/1ps
module usb_audio_fn #(
   parameter int REPORT_CYCLES = usb_audio_fn_pkg::REPORT_MS * usb_audio_fn_pkg::CLK_KHZ,
   parameter int IDLE_CYCLES = usb_audio_fn_pkg::IDLE_MS * usb_audio_fn_pkg::CLK_KHZ,
   parameter logic [15:0] VENDOR_ID = 16'h1234,  // arbitrary value
   parameter logic [15:0] PRODUCT_ID = 16'h5678  // arbitrary value
) (
   input wire logic mclk,
   input wire logic rst_b,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // descriptor fetch
   input wire logic [1:0] desc_sel,
   input wire logic [5:0] desc_idx,
   output logic [7:0] desc_byte,
   // decoded control requests
   input wire logic req_valid,
   input wire logic [1:0] req_kind,
   input wire logic [7:0] req_iface,
   input wire logic [7:0] req_entity,
   input wire logic [7:0] req_cs,
   input wire logic [7:0] req_ch,
   input wire logic [15:0] req_value,
   output logic req_done,
   output logic req_stall,
   output logic [15:0] req_rdata,
   // bus line state and full-speed attach
   input wire logic bus_idle,
   output logic fs_pullup_en,
   output logic suspend_flag_n,
   // keys and interrupt report
   input wire logic mute_key_in,
   input wire logic volume_up_key_in,
   input wire logic volume_down_key_in,
   output logic key_report_valid,
   output logic [2:0] key_report,
   // playback samples
   input wire logic sample_tick,
   input wire logic [15:0] sample_l,
   input wire logic [15:0] sample_r,
   output logic out_valid,
   output logic [15:0] out_l,
   output logic [15:0] out_r
);
   localparam int RW = $clog2(REPORT_CYCLES + 1);
   localparam int IW = $clog2(IDLE_CYCLES + 1);

   // refuse counts the counters cannot hold
   if (REPORT_CYCLES < 2 || IDLE_CYCLES < 2) begin : g_bad_count
      $error("timing counts must be at least two cycles");
   end

   logic [7:0] max_power_reg;
   logic [4:0] alt1_reg;
   logic [4:0] alt2_reg;
   logic mute_reg;
   logic [6:0] tgt_reg [2];
   logic [6:0] cur_reg [2];
   logic [2:0] keys_reg;
   logic [RW-1:0] rpt_cnt_reg;
   logic [IW-1:0] idle_cnt_reg;
   usb_audio_fn_pkg::susp_state_t susp_reg;
   logic [15:0] neg_val;
   logic vol_ok;
   logic [1:0] ch_idx;

   // full speed attach: d+ pull-up asserted once out of reset
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         fs_pullup_en <= 1'b0;
      end else begin
         fs_pullup_en <= 1'b1;
      end
   end

   // register writes: only max power is writable
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         max_power_reg <= usb_audio_fn_pkg::MAX_POWER_RST;
      end else if (reg_wr && reg_addr == usb_audio_fn_pkg::OFS_CFG) begin
         max_power_reg <= reg_wdata[7:0];
      end
   end

   // register reads, data in the following cycle, unmapped reads zero
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 32'h0;
      end else if (reg_rd) begin
         case (reg_addr)
            usb_audio_fn_pkg::OFS_CFG: reg_rdata <= {24'h0, max_power_reg};
            usb_audio_fn_pkg::OFS_STATUS: reg_rdata <= {9'h0, cur_reg[1], 1'b0,
               cur_reg[0], 3'h0, keys_reg, ~suspend_flag_n, mute_reg};
            usb_audio_fn_pkg::OFS_VOL: reg_rdata <= {17'h0, tgt_reg[1], 1'b0, tgt_reg[0]};
            usb_audio_fn_pkg::OFS_ALT: reg_rdata <= {19'h0, alt2_reg, 3'h0, alt1_reg};
            default: reg_rdata <= 32'h0;
         endcase
      end else begin
         reg_rdata <= 32'h0;
      end
   end

   // descriptor rom, registered output
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         desc_byte <= 8'h0;
      end else begin
         desc_byte <= 8'h0;
         case (desc_sel)
            usb_audio_fn_pkg::SEL_DEV: begin
               case (desc_idx)
                  6'h00: desc_byte <= usb_audio_fn_pkg::DESC_LEN_DEV;
                  6'h01: desc_byte <= usb_audio_fn_pkg::DESC_TYPE_DEV;
                  6'h02: desc_byte <= usb_audio_fn_pkg::BCD_USB[7:0];
                  6'h03: desc_byte <= usb_audio_fn_pkg::BCD_USB[15:8];
                  6'h07: desc_byte <= usb_audio_fn_pkg::EP0_SIZE;
                  6'h08: desc_byte <= VENDOR_ID[7:0];
                  6'h09: desc_byte <= VENDOR_ID[15:8];
                  6'h0A: desc_byte <= PRODUCT_ID[7:0];
                  6'h0B: desc_byte <= PRODUCT_ID[15:8];
                  6'h0C: desc_byte <= usb_audio_fn_pkg::BCD_DEV[7:0];
                  6'h0D: desc_byte <= usb_audio_fn_pkg::BCD_DEV[15:8];
                  6'h0E: desc_byte <= usb_audio_fn_pkg::STR_MFR;
                  6'h0F: desc_byte <= usb_audio_fn_pkg::STR_PROD;
                  6'h11: desc_byte <= usb_audio_fn_pkg::NUM_CFG;
                  default: desc_byte <= 8'h0;  // class fields zero
               endcase
            end
            usb_audio_fn_pkg::SEL_CFG: begin
               case (desc_idx)
                  6'h00: desc_byte <= usb_audio_fn_pkg::DESC_LEN_CFG;
                  6'h01: desc_byte <= usb_audio_fn_pkg::DESC_TYPE_CFG;
                  6'h04: desc_byte <= usb_audio_fn_pkg::NUM_IFACE;
                  6'h05: desc_byte <= usb_audio_fn_pkg::NUM_CFG;
                  6'h07: desc_byte <= usb_audio_fn_pkg::CFG_ATTR;
                  6'h08: desc_byte <= max_power_reg;
                  default: desc_byte <= 8'h0;
               endcase
            end
            usb_audio_fn_pkg::SEL_STR0: begin
               case (desc_idx)
                  6'h00: desc_byte <= 8'h04;
                  6'h01: desc_byte <= usb_audio_fn_pkg::DESC_TYPE_STR;
                  6'h02: desc_byte <= usb_audio_fn_pkg::LANG_ID[7:0];
                  6'h03: desc_byte <= usb_audio_fn_pkg::LANG_ID[15:8];
                  default: desc_byte <= 8'h0;
               endcase
            end
            usb_audio_fn_pkg::SEL_TOPO: begin
               // terminal type per entity, two bytes each, entity n at 2n
               case (desc_idx)
                  6'h02: desc_byte <= usb_audio_fn_pkg::TT_USB_STREAM[7:0];
                  6'h03: desc_byte <= usb_audio_fn_pkg::TT_USB_STREAM[15:8];
                  6'h04: desc_byte <= usb_audio_fn_pkg::TT_SPEAKER[7:0];
                  6'h05: desc_byte <= usb_audio_fn_pkg::TT_SPEAKER[15:8];
                  6'h06: desc_byte <= usb_audio_fn_pkg::TT_FEATURE[7:0];
                  6'h07: desc_byte <= usb_audio_fn_pkg::TT_FEATURE[15:8];
                  6'h08: desc_byte <= usb_audio_fn_pkg::TT_MIC[7:0];
                  6'h09: desc_byte <= usb_audio_fn_pkg::TT_MIC[15:8];
                  6'h0A: desc_byte <= usb_audio_fn_pkg::TT_USB_STREAM[7:0];
                  6'h0B: desc_byte <= usb_audio_fn_pkg::TT_USB_STREAM[15:8];
                  default: desc_byte <= 8'h0;
               endcase
            end
            default: desc_byte <= 8'h0;
         endcase
      end
   end

   // volume value check: 1/256 dB units, 0 down to -64 dB
   always_comb begin
      neg_val = 16'(-req_value);
      vol_ok = (req_value == 16'h0) || (req_value[15] &&
         neg_val <= {1'b0, usb_audio_fn_pkg::ATT_MAX, 8'h0});
      ch_idx = 2'(req_ch - 8'h01);
   end

   // request handling, answered one cycle after req_valid
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         req_done <= 1'b0;
         req_stall <= 1'b0;
         req_rdata <= 16'h0;
         alt1_reg <= 5'h0;
         alt2_reg <= 5'h0;
         mute_reg <= 1'b0;
         tgt_reg[0] <= 7'h0;
         tgt_reg[1] <= 7'h0;
      end else begin
         req_done <= req_valid;
         req_stall <= 1'b0;
         req_rdata <= 16'h0;
         if (req_valid) begin
            case (req_kind)
               usb_audio_fn_pkg::KIND_SET_IF: begin
                  case (req_iface)
                     8'h00: req_stall <= req_value != 16'h0;
                     8'h01: begin
                        if (req_value > {11'h0, usb_audio_fn_pkg::ALT_MAX_IF1}) begin
                           req_stall <= 1'b1;
                        end else begin
                           alt1_reg <= req_value[4:0];
                        end
                     end
                     8'h02: begin
                        if (req_value > {11'h0, usb_audio_fn_pkg::ALT_MAX_IF2}) begin
                           req_stall <= 1'b1;
                        end else begin
                           alt2_reg <= req_value[4:0];
                        end
                     end
                     8'h03: req_stall <= req_value != 16'h0;
                     default: req_stall <= 1'b1;  // only four interfaces
                  endcase
               end
               usb_audio_fn_pkg::KIND_SET_CUR, usb_audio_fn_pkg::KIND_GET_CUR: begin
                  if (req_entity != usb_audio_fn_pkg::FU_ENTITY) begin
                     req_stall <= 1'b1;
                  end else if (req_cs == usb_audio_fn_pkg::CS_MUTE) begin
                     if (req_ch != usb_audio_fn_pkg::CH_MASTER) begin
                        req_stall <= 1'b1;  // state untouched
                     end else if (req_kind == usb_audio_fn_pkg::KIND_SET_CUR) begin
                        mute_reg <= req_value[0];
                     end else begin
                        req_rdata <= {15'h0, mute_reg};
                     end
                  end else if (req_cs == usb_audio_fn_pkg::CS_VOLUME) begin
                     if (req_ch == usb_audio_fn_pkg::CH_MASTER || req_ch > 8'h02) begin
                        req_stall <= 1'b1;  // volume untouched
                     end else if (req_kind == usb_audio_fn_pkg::KIND_GET_CUR) begin
                        req_rdata <= 16'(-{1'b0, tgt_reg[ch_idx[0]], 8'h0});
                     end else if (!vol_ok) begin
                        req_stall <= 1'b1;
                     end else begin
                        tgt_reg[ch_idx[0]] <= neg_val[14:8];  // per channel
                     end
                  end else begin
                     req_stall <= 1'b1;  // volume and mute only
                  end
               end
               default: req_stall <= 1'b1;
            endcase
         end
      end
   end

   // applied attenuation and sample scaling per channel
   for (genvar c = 0; c < 2; c++) begin : g_ch
      logic [3:0] oct;
      logic [2:0] frac;
      logic [16:0] gain;
      logic signed [32:0] prod;
      logic [15:0] smp;
      logic [15:0] scaled;
      // step one dB per sample toward target
      always_ff @(posedge mclk or negedge rst_b) begin
         if (!rst_b) begin
            cur_reg[c] <= 7'h0;
         end else if (sample_tick) begin
            if (cur_reg[c] < tgt_reg[c]) begin
               cur_reg[c] <= cur_reg[c] + 7'h01;
            end else if (cur_reg[c] > tgt_reg[c]) begin
               cur_reg[c] <= cur_reg[c] - 7'h01;
            end
         end
      end
      // 6 dB per octave shift, fractional dB from a small table
      always_comb begin
         smp = (c == 0) ? sample_l : sample_r;
         oct = 4'(cur_reg[c] / 7'h06);
         frac = 3'(cur_reg[c] % 7'h06);
         case (frac)
            3'h0: gain = 17'h08000;
            3'h1: gain = 17'h07209;
            3'h2: gain = 17'h06598;
            3'h3: gain = 17'h05A82;
            3'h4: gain = 17'h050A3;
            default: gain = 17'h047D6;
         endcase
         prod = $signed(smp) * $signed(gain);
         scaled = 16'(prod >>> (usb_audio_fn_pkg::GAIN_SHIFT + int'(oct)));
      end
      // mute zeros the sample, scaled data return when cleared
      if (c == 0) begin : g_l
         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               out_l <= 16'h0;
            end else if (sample_tick) begin
               out_l <= mute_reg ? 16'h0 : scaled;
            end
         end
      end else begin : g_r
         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               out_r <= 16'h0;
            end else if (sample_tick) begin
               out_r <= mute_reg ? 16'h0 : scaled;
            end
         end
      end
   end

   // output sample strobe, one cycle after the tick
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         out_valid <= 1'b0;
      end else begin
         out_valid <= sample_tick;
      end
   end

   // key sampling; keys feed the report and the status register, never the attenuator
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         keys_reg <= 3'h0;
      end else begin
         keys_reg <= {volume_down_key_in, volume_up_key_in, mute_key_in};
      end
   end

   // periodic key report on the interrupt endpoint
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rpt_cnt_reg <= '0;
         key_report_valid <= 1'b0;
         key_report <= 3'h0;
      end else begin
         key_report_valid <= 1'b0;
         if (rpt_cnt_reg == RW'(REPORT_CYCLES - 1)) begin
            rpt_cnt_reg <= '0;
            key_report_valid <= 1'b1;
            key_report <= keys_reg;
         end else begin
            rpt_cnt_reg <= rpt_cnt_reg + RW'(1);
         end
      end
   end

   // suspend detect; wakes in the first non-idle cycle
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         susp_reg <= usb_audio_fn_pkg::SUSP_RUN;
         idle_cnt_reg <= '0;
         suspend_flag_n <= 1'b1;
      end else begin
         case (susp_reg)
            usb_audio_fn_pkg::SUSP_RUN: begin
               idle_cnt_reg <= '0;
               suspend_flag_n <= 1'b1;
               if (bus_idle) begin
                  susp_reg <= usb_audio_fn_pkg::SUSP_IDLE;
                  idle_cnt_reg <= IW'(1);
               end
            end
            usb_audio_fn_pkg::SUSP_IDLE: begin
               if (!bus_idle) begin
                  susp_reg <= usb_audio_fn_pkg::SUSP_RUN;
               end else if (idle_cnt_reg == IW'(IDLE_CYCLES - 1)) begin
                  susp_reg <= usb_audio_fn_pkg::SUSP_SLEEP;
                  suspend_flag_n <= 1'b0;
               end else begin
                  idle_cnt_reg <= idle_cnt_reg + IW'(1);
               end
            end
            usb_audio_fn_pkg::SUSP_SLEEP: begin
               if (!bus_idle) begin
                  susp_reg <= usb_audio_fn_pkg::SUSP_RUN;
                  suspend_flag_n <= 1'b1;
               end
            end
            default: susp_reg <= usb_audio_fn_pkg::SUSP_RUN;
         endcase
      end
   end
endmodule

// ===== core/usb_audio_fn_pkg.sv
// constants, layouts and encodings for the usb audio function control block
// Behaviour
// - all host traffic runs at usb full speed only; no other speed exists.
// - device descriptor: ep0 size 8, one configuration, class/subclass/protocol zero.
// - configuration attributes say bus powered, no remote wakeup.
// - max power defaults to 100 mA and software may replace it.
// - one configuration, four interfaces, each selectable only by defined alternates.
// - control interface zero accepts alternate setting zero only.
// - control topology holds five entities numbered one to five.
// - entity one is a usb streaming input terminal, stereo playback.
// - entity two is a speaker output terminal.
// - entity four is a microphone input terminal.
// - entity five is a usb streaming output terminal, stereo record.
// - feature unit three supports exactly volume and mute.
// - applied attenuation steps 1 dB per sample period toward target.
// - left and right volumes are held and applied independently.
// - master volume requests are stalled and leave volume unchanged.
// - mute is controlled only through the master channel.
// - per-channel mute requests are stalled and leave mute unchanged.
// - playback streaming interface has alternates zero to four, zero is idle.
// - each key input reads as pressed when high.
// - key inputs are only reported, never touch volume or mute.
// - suspend flag is low while suspended, high while operational.
// - key states are reported to the host every 32 ms.
// - suspend after 5 ms continuous idle, wake at once on non-idle.
package usb_audio_fn_pkg;
   // clock and long timings
   localparam int CLK_KHZ = 250000;
   localparam int REPORT_MS = 32;
   localparam int IDLE_MS = 5;
   // register byte offsets
   localparam logic [3:0] OFS_CFG = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_VOL = 4'h8;
   localparam logic [3:0] OFS_ALT = 4'hC;
   // reset values
   localparam logic [7:0] MAX_POWER_RST = 8'h32;
   // descriptor constants
   localparam logic [7:0] DESC_LEN_DEV = 8'h12;
   localparam logic [7:0] DESC_LEN_CFG = 8'h09;
   localparam logic [7:0] DESC_TYPE_DEV = 8'h01;
   localparam logic [7:0] DESC_TYPE_CFG = 8'h02;
   localparam logic [7:0] DESC_TYPE_STR = 8'h03;
   localparam logic [7:0] EP0_SIZE = 8'h08;
   localparam logic [7:0] NUM_CFG = 8'h01;
   localparam logic [7:0] NUM_IFACE = 8'h04;
   localparam logic [7:0] CFG_ATTR = 8'h80;
   localparam logic [15:0] BCD_USB = 16'h0200;
   localparam logic [15:0] BCD_DEV = 16'h0100;
   localparam logic [15:0] LANG_ID = 16'h0409;
   localparam logic [7:0] STR_MFR = 8'h01;
   localparam logic [7:0] STR_PROD = 8'h02;
   // terminal types of entities one to five
   localparam logic [15:0] TT_USB_STREAM = 16'h0101;
   localparam logic [15:0] TT_SPEAKER = 16'h0301;
   localparam logic [15:0] TT_MIC = 16'h0201;
   localparam logic [15:0] TT_FEATURE = 16'h0000;
   localparam logic [7:0] FU_ENTITY = 8'h03;
   // alternate setting limits
   localparam logic [4:0] ALT_MAX_IF1 = 5'h04;
   localparam logic [4:0] ALT_MAX_IF2 = 5'h12;
   // volume in 1/256 dB, attenuation in whole dB
   localparam logic [6:0] ATT_MAX = 7'h40;
   localparam int GAIN_SHIFT = 15;
   typedef enum logic [1:0] {SEL_DEV = 2'h0, SEL_CFG = 2'h1, SEL_STR0 = 2'h2,
      SEL_TOPO = 2'h3} desc_sel_t;
   typedef enum logic [1:0] {KIND_SET_IF = 2'h0, KIND_SET_CUR = 2'h1,
      KIND_GET_CUR = 2'h2, KIND_OTHER = 2'h3} req_kind_t;
   localparam logic [7:0] CS_MUTE = 8'h01;
   localparam logic [7:0] CS_VOLUME = 8'h02;
   localparam logic [7:0] CH_MASTER = 8'h00;
   typedef enum logic [2:0] {SUSP_RUN = 3'b001, SUSP_IDLE = 3'b010,
      SUSP_SLEEP = 3'b100} susp_state_t;
endpackage

// ===== tb/testbench.sv
// self-checking bench for the usb audio function control block
`timescale 1ns/1ps
module testbench;
   logic mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sample_tick = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
   logic [1:0] desc_sel = 2'h0, req_kind;
   logic [5:0] desc_idx = 6'h0;
   logic [7:0] desc_byte, req_iface, req_entity, req_cs, req_ch;
   logic req_valid, req_done, req_stall, bus_idle, fs_pullup_en, suspend_flag_n, dn, st;
   logic [15:0] req_value, req_rdata, out_l, out_r, rd;
   logic [15:0] sample_l = 16'h4000, sample_r = 16'hC000;
   logic mute_key_in = 1'b0, volume_up_key_in = 1'b0, volume_down_key_in = 1'b0;
   logic key_report_valid, out_valid;
   logic [2:0] key_report;
   int num_errors = 0, tests_run = 0, cyc = 0;
   localparam int G [6] = '{32'h8000, 32'h7209, 32'h6598, 32'h5A82, 32'h50A3, 32'h47D6};
   // {sel, idx, byte} expected in the descriptor roms
   localparam logic [15:0] DT [23] = '{16'h0012, 16'h0101, 16'h0400, 16'h0500, 16'h0600,
      16'h0708, 16'h1101, 16'h4102, 16'h4404, 16'h4780, 16'h4832, 16'h8103, 16'h8209,
      16'h8304, 16'hC201, 16'hC301, 16'hC401, 16'hC503, 16'hC600, 16'hC801, 16'hC902,
      16'hCA01, 16'hCB01};
   // short counts keep the run brief
   usb_audio_fn #(.REPORT_CYCLES(20), .IDLE_CYCLES(10)) i_usb_audio_fn (.mclk, .rst_b,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .desc_sel, .desc_idx, .desc_byte,
      .req_valid, .req_kind, .req_iface, .req_entity, .req_cs, .req_ch, .req_value,
      .req_done, .req_stall, .req_rdata, .bus_idle, .fs_pullup_en, .suspend_flag_n,
      .mute_key_in, .volume_up_key_in, .volume_down_key_in, .key_report_valid, .key_report,
      .sample_tick, .sample_l, .sample_r, .out_valid, .out_l, .out_r);
   usb_host_model i_usb_host_model (.mclk, .req_done, .req_stall, .req_rdata, .req_valid,
      .req_kind, .req_iface, .req_entity, .req_cs, .req_ch, .req_value, .bus_idle);
   // clock and hang guard
   initial forever #2 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors++;
         end_sim;
      end
   end
   task automatic end_sim;
      if (num_errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // attenuated sample, floor of the arithmetic shift
   function automatic logic [15:0] gain(input logic signed [15:0] s, input int a);
      return 16'((int'(s) * G[a % 6]) >>> (15 + a / 6));
   endfunction
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rdr(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic desc(input logic [15:0] t);
      @(posedge mclk);
      desc_sel <= t[15:14];
      desc_idx <= t[13:8];
      @(posedge mclk);
      #1 chk(desc_byte, t[7:0]);
   endtask
   task automatic q(input logic [1:0] k, input logic [7:0] i, e, c, h, input logic [15:0] v,
      input logic s);
      i_usb_host_model.send(k, i, e, c, h, v, dn, st, rd);
      chk({dn, st}, {1'b1, s});
   endtask
   task automatic tick;
      @(posedge mclk);
      sample_tick <= 1'b1;
      @(posedge mclk);
      sample_tick <= 1'b0;
      #1 chk(out_valid, 1'b1);
   endtask
   task automatic t_regs;
      chk({fs_pullup_en, suspend_flag_n}, 2'h3);
      rdr(usb_audio_fn_pkg::OFS_CFG, rv);
      chk(rv, 32'h32);
      wr(usb_audio_fn_pkg::OFS_CFG, 32'h40);
      wr(usb_audio_fn_pkg::OFS_STATUS, 32'hFFFFFFFF);
      wr(4'h2, 32'hFF);
      rdr(usb_audio_fn_pkg::OFS_STATUS, rv);
      chk(rv, 32'h0);
      rdr(4'h2, rv);
      chk(rv, 32'h0);
      desc(16'h4840);
   endtask
   task automatic t_req;
      q(0, 0, 0, 0, 0, 0, 0);
      q(0, 0, 0, 0, 0, 1, 1);
      q(0, 1, 0, 0, 0, 4, 0);
      q(0, 1, 0, 0, 0, 5, 1);
      q(0, 2, 0, 0, 0, 18, 0);
      q(0, 2, 0, 0, 0, 19, 1);
      q(0, 3, 0, 0, 0, 1, 1);
      q(0, 4, 0, 0, 0, 0, 1);
      q(1, 0, 3, 1, 1, 1, 1);
      q(1, 0, 3, 1, 2, 1, 1);
      q(1, 0, 2, 2, 1, 16'hF600, 1);
      q(1, 0, 3, 3, 1, 0, 1);
      q(3, 0, 3, 2, 1, 0, 1);
      q(1, 0, 3, 2, 1, 16'hBF00, 1);
      q(1, 0, 3, 2, 1, 16'h0100, 1);
      q(1, 0, 3, 2, 1, 16'hC000, 0);
      q(1, 0, 3, 2, 1, 16'hF600, 0);
      q(1, 0, 3, 2, 2, 16'hFE00, 0);
      q(1, 0, 3, 2, 0, 16'hF600, 1);
      q(2, 0, 3, 2, 1, 0, 0);
      chk(rd, 16'hF600);
      rdr(usb_audio_fn_pkg::OFS_ALT, rv);
      chk(rv, 32'h1204);
      rdr(usb_audio_fn_pkg::OFS_VOL, rv);
      chk(rv, 32'h020A);
      rdr(usb_audio_fn_pkg::OFS_STATUS, rv);
      chk(rv[0], 1'b0);
   endtask
   task automatic t_vol;
      for (int n = 1; n <= 3; n++) begin
         tick;
         chk({out_l, out_r}, {gain(sample_l, n - 1), gain(sample_r, n > 2 ? 2 : n - 1)});
         rdr(usb_audio_fn_pkg::OFS_STATUS, rv);
         chk({rv[22:16], rv[14:8]}, {7'((n > 2) ? 2 : n), 7'(n)});
      end
      q(1, 0, 3, 1, 0, 1, 0);
      q(2, 0, 3, 1, 0, 0, 0);
      chk(rd, 16'h1);
      tick;
      chk({out_l, out_r}, 32'h0);
      q(1, 0, 3, 1, 0, 0, 0);
      repeat (11) tick;
      chk({out_l, out_r}, {gain(sample_l, 10), gain(sample_r, 2)});
   endtask
   task automatic t_keys;
      @(posedge mclk);
      {volume_down_key_in, volume_up_key_in, mute_key_in} <= 3'h5;
      repeat (3) @(posedge mclk);
      for (int n = 0; n < 45 && key_report_valid !== 1'b1; n++) begin
         @(posedge mclk);
         #1;
      end
      chk(key_report, 3'h5);
      rdr(usb_audio_fn_pkg::OFS_STATUS, rv);
      chk({rv[14:8], rv[0]}, {7'h0A, 1'b0});
   endtask
   task automatic t_susp;
      i_usb_host_model.idle(1'b1);
      repeat (9) @(posedge mclk);
      #1 chk(suspend_flag_n, 1'b1);
      @(posedge mclk);
      #1 chk(suspend_flag_n, 1'b0);
      i_usb_host_model.idle(1'b0);
      @(posedge mclk);
      #1 chk(suspend_flag_n, 1'b1);
   endtask
   // main sequence
   initial begin
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (2) @(posedge mclk);
      foreach (DT[j]) desc(DT[j]);
      t_regs;
      t_req;
      t_vol;
      t_keys;
      t_susp;
      end_sim;
   end
endmodule

// ===== tb/usb_audio_fn_chk.sv
// port assertions for the usb audio function control block
`timescale 1ns/1ps
module usb_audio_fn_chk (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic req_valid,
   input wire logic req_done,
   input wire logic req_stall,
   input wire logic bus_idle,
   input wire logic fs_pullup_en,
   input wire logic suspend_flag_n,
   input wire logic mute_key_in,
   input wire logic volume_up_key_in,
   input wire logic volume_down_key_in,
   input wire logic key_report_valid,
   input wire logic [2:0] key_report,
   input wire logic sample_tick,
   input wire logic out_valid
);
   // key lines in report order
   wire logic [2:0] keys = {volume_down_key_in, volume_up_key_in, mute_key_in};
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   req_answer_a: assert property (req_valid |=> req_done)
      else $error("request not answered next cycle");
   no_stray_done_a: assert property (!req_valid |=> !req_done && !req_stall)
      else $error("answer without request");
   stall_done_a: assert property (req_stall |-> req_done)
      else $error("stall outside answer");
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data outside read cycle");
   sample_out_a: assert property (sample_tick |=> out_valid)
      else $error("sample output missing");
   wake_now_a: assert property (!bus_idle |=> suspend_flag_n)
      else $error("suspended across non-idle bus");
   sleep_cause_a: assert property ($fell(suspend_flag_n) |-> $past(bus_idle))
      else $error("suspend without idle bus");
   key_state_a: assert property (key_report_valid && keys == $past(keys)
      && keys == $past(keys, 2) |-> key_report == keys) else $error("key report wrong");
   report_gap_a: assert property (key_report_valid |=> !key_report_valid [*8])
      else $error("reports too close");
   attach_fs_a: assert property ($past(rst_b) |-> fs_pullup_en)
      else $error("full-speed attach missing");
endmodule
bind usb_audio_fn usb_audio_fn_chk i_usb_audio_fn_chk (.mclk, .rst_b, .reg_rd, .reg_rdata,
   .req_valid, .req_done, .req_stall, .bus_idle, .fs_pullup_en, .suspend_flag_n, .mute_key_in,
   .volume_up_key_in, .volume_down_key_in, .key_report_valid, .key_report, .sample_tick,
   .out_valid);

// ===== tb/usb_host_model.sv
// host side model: issues control requests and sets the bus line state
`timescale 1ns/1ps
module usb_host_model (
   input wire logic mclk,
   input wire logic req_done,
   input wire logic req_stall,
   input wire logic [15:0] req_rdata,
   output logic req_valid,
   output logic [1:0] req_kind,
   output logic [7:0] req_iface,
   output logic [7:0] req_entity,
   output logic [7:0] req_cs,
   output logic [7:0] req_ch,
   output logic [15:0] req_value,
   output logic bus_idle
);
   // full-speed host only, bus busy from power-up
   initial begin
      {req_valid, req_kind, req_iface, req_entity, req_cs, req_ch, req_value, bus_idle} = '0;
   end
   // one request, answer read in the following cycle
   task automatic send(input logic [1:0] k, input logic [7:0] i, e, c, h,
      input logic [15:0] v, output logic dn, output logic st, output logic [15:0] rd);
      @(posedge mclk);
      req_valid <= 1'b1;
      {req_kind, req_iface, req_entity, req_cs, req_ch, req_value} <= {k, i, e, c, h, v};
      @(posedge mclk);
      req_valid <= 1'b0;
      req_value <= ~v; // released value is scrambled
      #1 {dn, st, rd} = {req_done, req_stall, req_rdata};
   endtask
   // line state change right after an edge
   task automatic idle(input logic b);
      @(posedge mclk);
      bus_idle <= b;
   endtask
endmodule
